//--- liu_regmap_defines.vh
`ifndef LIU_REGMAP_DEFINES_VH
`define LIU_REGMAP_DEFINES_VH

// Address byte fields
`define LIU_RW_BIT 0
`define LIU_SUB_LSB 1
`define LIU_SUB_MSB 3
`define LIU_PORT_LSB 4
`define LIU_PORT_MSB 7
`define LIU_READ_FLAG 1'b1

// Port select values
`define LIU_PORT_GLOBAL 4'h0
`define LIU_PORT_CH0 4'h1
`define LIU_PORT_CH1 4'h2

// Global sub-addresses
`define LIU_SUB_MASTER 3'h0
`define LIU_SUB_GLOBAL_INTERRUPT_CONTROL 3'h1
`define LIU_SUB_GRSVD 3'h2

// Channel sub-addresses
`define LIU_SUB_MODE 3'h0
`define LIU_SUB_SIGNAL 3'h1
`define LIU_SUB_ADV_ONE 3'h2
`define LIU_SUB_ADV_ZERO 3'h3
`define LIU_SUB_MODE_TWO 3'h4
`define LIU_SUB_STATUS 3'h5

// Master control fields
`define LIU_MC_RATE 7
`define LIU_MC_PAR 5
`define LIU_MC_REF_MSB 4
`define LIU_MC_REF_LSB 3
`define LIU_MC_SOFT_REG_RESET 0

// Interrupt control fields
`define LIU_IC_POL 7
`define LIU_IC_LOL_PASS 1
`define LIU_IC_FERR_PASS 0

// Latched status vector positions
`define LIU_CS_FERR 0
`define LIU_CS_TX_LOCK_LOSS 1
`define LIU_CS_RXLOL 2
`define LIU_CS_RXSIG 3

// Reset values
`define LIU_MC_RESET 8'h00
`define LIU_IC_RESET 8'h23
`define LIU_GR_RESET 8'h00
`define LIU_MODE_RESET 8'h01
`define LIU_SIGNAL_RESET 8'h00
`define LIU_ADV_ONE_RESET 8'h00
`define LIU_ADV_ZERO_RESET 8'ha8
`define LIU_MODE_TWO_RESET 8'h80

// Serial frame
`define LIU_LAST_BIT 4'h7
`define LIU_BYTE_BITS 4'h8

`endif

//--- liu_sync.v
module liu_sync #(
  parameter WIDTH = 1
) (
  input wire clock_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  // Two-stage synchroniser, first stage read only by second
  // No reset, so pin levels pass through while reset is held
  always @(posedge clock_i) begin
    meta <= async_i;
    sync_o <= meta;
  end

endmodule // liu_sync

//--- liu_status.v
module liu_status (
  input wire clock_i,
  input wire reset_i,
  input wire clear_i,
  input wire read_clear_i,
  input wire [3:0] cond_i,
  output reg [3:0] status_o
);

  // Sticky status, cleared by a read; a new event beats the clear
  always @(posedge clock_i) begin
    if (reset_i || clear_i) begin
      status_o <= 4'h0;
    end else begin
      status_o <= (status_o & ~{4{read_clear_i}}) | cond_i;
    end
  end

endmodule // liu_status

//--- liu_regmap.v
`include "liu_regmap_defines.vh"

module liu_regmap (
  input wire clock_i,
  input wire reset_i,
  input wire serial_enable_pin_i,
  input wire serial_clock_pin_i,
  input wire serial_in_pin_i,
  input wire [1:0] refclk_sel_strap_i,
  input wire [1:0] tx_lock_loss_i,
  input wire [1:0] fifo_error_i,
  input wire [1:0] rx_lock_loss_i,
  input wire [1:0] rx_signal_loss_i,
  output reg serial_out_pin_o,
  output reg serial_out_oe_o,
  output wire line_rate_sel_o,
  output wire parallel_iface_sel_o,
  output wire [1:0] refclk_freq_sel_o,
  output wire [15:0] channel_mode_control_o,
  output wire [15:0] channel_signal_control_o,
  output wire [15:0] channel_advanced_tx_one_o,
  output wire [15:0] channel_advanced_tx_zero_o,
  output wire [15:0] channel_mode_control_two_o,
  output wire [1:0] tx_irq_pin_o
);

  // Serial frame states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WDATA = 3'h2;
  localparam ST_RDATA = 3'h3;
  localparam ST_DONE = 3'h4;

  // Synchronised pin levels
  wire sen_s;
  wire sck_s;
  wire sdi_s;
  wire [1:0] strap_s;
  wire [1:0] tx_lock_loss_s;
  wire [1:0] ferr_s;
  wire [1:0] rxlol_s;
  wire [1:0] rxsig_s;

  // Serial engine
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] addr;
  reg [7:0] wdata;
  reg [7:0] rshift;
  reg wr_stb;
  reg sck_d;
  wire sck_rise;
  wire sck_fall;
  wire [7:0] next_addr;
  wire [7:0] next_wdata;
  wire addr_done;
  wire [3:0] port;
  wire [2:0] sub;
  wire [3:0] next_port;
  wire [2:0] next_sub;

  // Register storage
  reg [7:0] global_master_control;
  reg [7:0] global_interrupt_control;
  reg [7:0] global_reserved;
  reg [7:0] channel_mode_control [0:1];
  reg [7:0] channel_signal_control [0:1];
  reg [7:0] channel_advanced_tx_one [0:1];
  reg [7:0] channel_advanced_tx_zero [0:1];
  reg [7:0] channel_mode_control_two [0:1];
  reg soft_reg_reset;
  reg [7:0] rd_val;
  wire [7:0] status_all;
  wire [1:0] rd_clr;
  integer i;

  // True for the two channel ports
  function chan_hit;
    input [3:0] p;
    begin
      chan_hit = (p == `LIU_PORT_CH0) || (p == `LIU_PORT_CH1);
    end
  endfunction

  // Channel index of a channel port
  function chan_idx;
    input [3:0] p;
    begin
      chan_idx = (p == `LIU_PORT_CH1);
    end
  endfunction

  // Status byte layout of one channel
  function [7:0] status_byte;
    input [3:0] s;
    begin
      status_byte = {3'h0, s[`LIU_CS_RXSIG], s[`LIU_CS_RXLOL], 1'b0,
        s[`LIU_CS_TX_LOCK_LOSS], s[`LIU_CS_FERR]};
    end
  endfunction

  // All pins and status inputs cross into the clock domain
  // Unreset, so the strap level is ready for the reset load
  liu_sync #(
    .WIDTH(13)
  ) u_sync (
    .clock_i(clock_i),
    .async_i({serial_enable_pin_i, serial_clock_pin_i, serial_in_pin_i,
      refclk_sel_strap_i, tx_lock_loss_i, fifo_error_i,
      rx_lock_loss_i, rx_signal_loss_i}),
    .sync_o({sen_s, sck_s, sdi_s, strap_s, tx_lock_loss_s, ferr_s,
      rxlol_s, rxsig_s})
  );

  // Serial clock edge detection on the synchronised level
  always @(posedge clock_i) begin
    if (reset_i) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;

  // Bits enter at the top, so the first bit ends in bit 0
  assign next_addr = {sdi_s, addr[7:1]};
  assign next_wdata = {sdi_s, wdata[7:1]};
  assign addr_done = (state == ST_ADDR) && sck_rise &&
    (bit_cnt == `LIU_LAST_BIT);

  // Address byte field split
  assign port = addr[`LIU_PORT_MSB:`LIU_PORT_LSB];
  assign sub = addr[`LIU_SUB_MSB:`LIU_SUB_LSB];
  assign next_port = next_addr[`LIU_PORT_MSB:`LIU_PORT_LSB];
  assign next_sub = next_addr[`LIU_SUB_MSB:`LIU_SUB_LSB];

  // Serial frame sequencer
  always @(posedge clock_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      addr <= 8'h00;
      wdata <= 8'h00;
      rshift <= 8'h00;
      wr_stb <= 1'b0;
      serial_out_pin_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (!sen_s) begin
        // Frame ended or aborted: release the data pin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        serial_out_oe_o <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            bit_cnt <= 4'h0;
            state <= ST_ADDR;
          end
          ST_ADDR: begin
            if (sck_rise) begin
              addr <= next_addr;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `LIU_LAST_BIT) begin
                bit_cnt <= 4'h0;
                if (next_addr[`LIU_RW_BIT] == `LIU_READ_FLAG) begin
                  rshift <= rd_val;
                  state <= ST_RDATA;
                end else begin
                  state <= ST_WDATA;
                end
              end
            end
          end
          ST_WDATA: begin
            if (sck_rise) begin
              wdata <= next_wdata;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `LIU_LAST_BIT) begin
                wr_stb <= 1'b1;
                state <= ST_DONE;
              end
            end
          end
          ST_RDATA: begin
            // Drive one bit per falling edge, LSB first
            if (sck_fall) begin
              if (bit_cnt == `LIU_BYTE_BITS) begin
                serial_out_oe_o <= 1'b0;
                state <= ST_DONE;
              end else begin
                serial_out_pin_o <= rshift[0];
                serial_out_oe_o <= 1'b1;
                rshift <= {1'b0, rshift[7:1]};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_DONE: begin
            serial_out_oe_o <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Read data selection from the address being completed
  always @* begin
    rd_val = 8'h00;
    if (next_port == `LIU_PORT_GLOBAL) begin
      case (next_sub)
        `LIU_SUB_MASTER: rd_val = {global_master_control[7:1], 1'b0};
        `LIU_SUB_GLOBAL_INTERRUPT_CONTROL: rd_val = global_interrupt_control;
        `LIU_SUB_GRSVD: rd_val = global_reserved;
        default: rd_val = 8'h00;
      endcase
    end else if (chan_hit(next_port)) begin
      case (next_sub)
        `LIU_SUB_MODE:
          rd_val = channel_mode_control[chan_idx(next_port)];
        `LIU_SUB_SIGNAL:
          rd_val = channel_signal_control[chan_idx(next_port)];
        `LIU_SUB_ADV_ONE:
          rd_val = channel_advanced_tx_one[chan_idx(next_port)];
        `LIU_SUB_ADV_ZERO:
          rd_val = channel_advanced_tx_zero[chan_idx(next_port)];
        `LIU_SUB_MODE_TWO:
          rd_val = channel_mode_control_two[chan_idx(next_port)];
        `LIU_SUB_STATUS: begin
          if (chan_idx(next_port)) begin
            rd_val = status_byte(status_all[7:4]);
          end else begin
            rd_val = status_byte(status_all[3:0]);
          end
        end
        default: rd_val = 8'h00;
      endcase
    end
  end

  // Soft reset pulse, one cycle after the write, never stored
  always @(posedge clock_i) begin
    if (reset_i) begin
      soft_reg_reset <= 1'b0;
    end else begin
      soft_reg_reset <= wr_stb && (port == `LIU_PORT_GLOBAL) &&
        (sub == `LIU_SUB_MASTER) && wdata[`LIU_MC_SOFT_REG_RESET];
    end
  end

  // Global registers; invalid ports fall through untouched
  always @(posedge clock_i) begin
    if (reset_i || soft_reg_reset) begin
      global_master_control <= `LIU_MC_RESET;
      global_master_control[`LIU_MC_REF_MSB:`LIU_MC_REF_LSB] <=
        strap_s;
      global_interrupt_control <= `LIU_IC_RESET;
      global_reserved <= `LIU_GR_RESET;
    end else if (wr_stb && (port == `LIU_PORT_GLOBAL)) begin
      case (sub)
        `LIU_SUB_MASTER: begin
          global_master_control <= {wdata[7:1], 1'b0};
        end
        `LIU_SUB_GLOBAL_INTERRUPT_CONTROL: begin
          global_interrupt_control <= wdata;
        end
        `LIU_SUB_GRSVD: begin
          global_reserved <= wdata;
        end
        default: begin
          global_reserved <= global_reserved;
        end
      endcase
    end
  end

  // Channel registers, one set per channel port
  always @(posedge clock_i) begin
    if (reset_i || soft_reg_reset) begin
      for (i = 0; i < 2; i = i + 1) begin
        channel_mode_control[i] <= `LIU_MODE_RESET;
        channel_signal_control[i] <= `LIU_SIGNAL_RESET;
        channel_advanced_tx_one[i] <= `LIU_ADV_ONE_RESET;
        channel_advanced_tx_zero[i] <= `LIU_ADV_ZERO_RESET;
        channel_mode_control_two[i] <= `LIU_MODE_TWO_RESET;
      end
    end else if (wr_stb && chan_hit(port)) begin
      case (sub)
        `LIU_SUB_MODE:
          channel_mode_control[chan_idx(port)] <= wdata;
        `LIU_SUB_SIGNAL:
          channel_signal_control[chan_idx(port)] <= wdata;
        `LIU_SUB_ADV_ONE:
          channel_advanced_tx_one[chan_idx(port)] <= wdata;
        `LIU_SUB_ADV_ZERO:
          channel_advanced_tx_zero[chan_idx(port)] <= wdata;
        `LIU_SUB_MODE_TWO:
          channel_mode_control_two[chan_idx(port)] <= wdata;
        default: begin
          channel_mode_control[0] <= channel_mode_control[0];
        end
      endcase
    end
  end

  // Global controls out to the line logic
  assign line_rate_sel_o = global_master_control[`LIU_MC_RATE];
  assign parallel_iface_sel_o = global_master_control[`LIU_MC_PAR];
  assign refclk_freq_sel_o =
    global_master_control[`LIU_MC_REF_MSB:`LIU_MC_REF_LSB];

  // Per-channel status, interrupt pin and control outputs
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      reg irq_pin;
      wire [3:0] st;
      wire irq_active;

      // Read of this channel's status clears it in the same cycle
      assign rd_clr[g] = addr_done &&
        (next_addr[`LIU_RW_BIT] == `LIU_READ_FLAG) &&
        chan_hit(next_port) && (chan_idx(next_port) == g) &&
        (next_sub == `LIU_SUB_STATUS);

      liu_status u_status (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clear_i(soft_reg_reset),
        .read_clear_i(rd_clr[g]),
        .cond_i({rxsig_s[g], rxlol_s[g], tx_lock_loss_s[g], ferr_s[g]}),
        .status_o(st)
      );

      assign status_all[4*g+3:4*g] = st;

      // Independent masks gate the two transmit events
      assign irq_active =
        (st[`LIU_CS_TX_LOCK_LOSS] &
         global_interrupt_control[`LIU_IC_LOL_PASS]) |
        (st[`LIU_CS_FERR] &
         global_interrupt_control[`LIU_IC_FERR_PASS]);

      // Registered pin at the programmed polarity, idle high at reset
      always @(posedge clock_i) begin
        if (reset_i) begin
          irq_pin <= 1'b1;
        end else if (global_interrupt_control[`LIU_IC_POL]) begin
          irq_pin <= irq_active;
        end else begin
          irq_pin <= ~irq_active;
        end
      end

      assign tx_irq_pin_o[g] = irq_pin;
      assign channel_mode_control_o[8*g+7:8*g] = channel_mode_control[g];
      assign channel_signal_control_o[8*g+7:8*g] =
        channel_signal_control[g];
      assign channel_advanced_tx_one_o[8*g+7:8*g] =
        channel_advanced_tx_one[g];
      assign channel_advanced_tx_zero_o[8*g+7:8*g] =
        channel_advanced_tx_zero[g];
      assign channel_mode_control_two_o[8*g+7:8*g] =
        channel_mode_control_two[g];
    end
  endgenerate

endmodule // liu_regmap

//--- liu_regmap_asserts.sv
module liu_regmap_asserts (
  input wire clock_i,
  input wire reset_i,
  input wire serial_enable_pin_i,
  input wire serial_clock_pin_i,
  input wire [1:0] refclk_sel_strap_i,
  input wire serial_out_pin_o,
  input wire serial_out_oe_o,
  input wire line_rate_sel_o,
  input wire parallel_iface_sel_o,
  input wire [1:0] refclk_freq_sel_o,
  input wire [15:0] channel_mode_control_o,
  input wire [15:0] channel_signal_control_o,
  input wire [15:0] channel_mode_control_two_o,
  input wire [1:0] tx_irq_pin_o
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Data pin driven only inside a read frame
  property p_oe_idle;
    !serial_enable_pin_i [*6] |-> !serial_out_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pin driven outside a frame");
  property p_oe_en;
    $rose(serial_out_oe_o) |-> serial_enable_pin_i;
  endproperty
  a_oe_en: assert property (p_oe_en)
    else $error("data pin enabled without frame enable");
  // Read bits launched by falling link clock edges
  property p_oe_rise;
    $rose(serial_out_oe_o) |->
      !$past(serial_clock_pin_i, 2) && !$past(serial_clock_pin_i, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data pin enabled away from a falling edge");
  property p_sdo_fall;
    serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_pin_o)
      |-> !$past(serial_clock_pin_i, 2) && !$past(serial_clock_pin_i, 3);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("read bit changed away from a falling edge");
  property p_sdo_hold;
    (serial_out_oe_o && serial_clock_pin_i) [*3] ##1
      (serial_out_oe_o && serial_clock_pin_i) |-> $stable(serial_out_pin_o);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("read bit moved while link clock high");
  // Defaults seen at release of reset
  property p_reset_vals;
    $fell(reset_i) |-> !line_rate_sel_o && !parallel_iface_sel_o &&
      channel_mode_control_o == 16'h0101 &&
      channel_signal_control_o == 16'h0000 &&
      channel_mode_control_two_o == 16'h8080 && tx_irq_pin_o == 2'b11;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong default after reset");
  property p_strap;
    $fell(reset_i) |-> refclk_freq_sel_o == refclk_sel_strap_i;
  endproperty
  a_strap: assert property (p_strap)
    else $error("reference select not loaded from strap");
  // Configuration moves only inside a frame
  property p_cfg_quiet;
    $changed({line_rate_sel_o, parallel_iface_sel_o, refclk_freq_sel_o,
      channel_mode_control_o, channel_signal_control_o})
      |-> $past(serial_enable_pin_i);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("configuration changed outside a frame");

  // Main scenarios reached
  c_read: cover property ($rose(serial_out_oe_o));
  c_irq: cover property (tx_irq_pin_o == 2'b10);
  c_strap: cover property ($changed(refclk_freq_sel_o));
endmodule // liu_regmap_asserts

bind liu_regmap liu_regmap_asserts liu_regmap_asserts_inst (
  .clock_i(clock_i), .reset_i(reset_i),
  .serial_enable_pin_i(serial_enable_pin_i),
  .serial_clock_pin_i(serial_clock_pin_i),
  .refclk_sel_strap_i(refclk_sel_strap_i),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o),
  .line_rate_sel_o(line_rate_sel_o),
  .parallel_iface_sel_o(parallel_iface_sel_o),
  .refclk_freq_sel_o(refclk_freq_sel_o),
  .channel_mode_control_o(channel_mode_control_o),
  .channel_signal_control_o(channel_signal_control_o),
  .channel_mode_control_two_o(channel_mode_control_two_o),
  .tx_irq_pin_o(tx_irq_pin_o)
);

//--- liu_host.sv
module liu_host (
  input wire clock_i,
  input wire serial_out_pin_i,
  input wire serial_out_oe_i,
  output logic enable_o,
  output logic sck_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: no frame, link clock parked low
  initial begin
    enable_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // One access per frame; read bits taken just before the next fall
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
      input int nbits, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {d, a};
    rdata = 8'h00;
    @(negedge clock_i);
    enable_o = 1'b1;
    repeat (4) @(negedge clock_i);
    for (int i = 0; i <= nbits; i++) begin
      if (a[0] && i >= 9)
        rdata[i-9] = serial_out_oe_i ? serial_out_pin_i : 1'bx;
      sck_o = 1'b0;
      if (i < nbits) begin
        sdi_o = frame[i];
        repeat (4) @(negedge clock_i);
        sck_o = 1'b1;
        repeat (4) @(negedge clock_i);
      end
    end
    repeat (4) @(negedge clock_i);
    enable_o = 1'b0;
    sdi_o = ~sdi_o; // Released line shows no stale bit
    repeat (4) @(negedge clock_i);
  endtask
endmodule // liu_host

//--- liu_register_map_and_irq_tb_top.sv
module liu_register_map_and_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } liu_row_t;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] strap = 2'b10;
  logic [1:0] tx_lol = 2'b00;
  logic [1:0] ferr = 2'b00;
  logic [1:0] rx_lol = 2'b00;
  logic [1:0] rx_los = 2'b00;
  wire en, sck, sdi, sdo, oe, rate, par;
  wire [1:0] refclk, irq;
  wire [15:0] mode, sig, mode2, adv1, adv0;
  logic [7:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  // Address, write data, expected read data
  liu_row_t rows [0:17] = '{
    '{8'h01, 8'h00, 8'h10}, '{8'h03, 8'h00, 8'h23}, '{8'h11, 8'h00, 8'h01},
    '{8'h27, 8'h00, 8'ha8}, '{8'h19, 8'h00, 8'h80}, '{8'h00, 8'hb8, 8'h00},
    '{8'h01, 8'h00, 8'hb8}, '{8'h02, 8'h5e, 8'h00}, '{8'h03, 8'h00, 8'h5e},
    '{8'h30, 8'hff, 8'h00}, '{8'h31, 8'h00, 8'h00}, '{8'h22, 8'h5a, 8'h00},
    '{8'h23, 8'h00, 8'h5a}, '{8'h13, 8'h00, 8'h00}, '{8'hf0, 8'hff, 8'h00},
    '{8'h01, 8'h00, 8'hb8}, '{8'h04, 8'h3c, 8'h00}, '{8'h05, 8'h00, 8'h3c}};

  // Clock at 20 MHz
  always #25 clock_i = ~clock_i;

  liu_regmap liu_regmap_inst (
    .clock_i(clock_i), .reset_i(reset_i),
    .serial_enable_pin_i(en), .serial_clock_pin_i(sck),
    .serial_in_pin_i(sdi), .refclk_sel_strap_i(strap),
    .tx_lock_loss_i(tx_lol), .fifo_error_i(ferr),
    .rx_lock_loss_i(rx_lol), .rx_signal_loss_i(rx_los),
    .serial_out_pin_o(sdo), .serial_out_oe_o(oe),
    .line_rate_sel_o(rate), .parallel_iface_sel_o(par),
    .refclk_freq_sel_o(refclk), .channel_mode_control_o(mode),
    .channel_signal_control_o(sig), .channel_advanced_tx_one_o(adv1),
    .channel_advanced_tx_zero_o(adv0), .channel_mode_control_two_o(mode2),
    .tx_irq_pin_o(irq)
  );

  liu_host liu_host_inst (
    .clock_i(clock_i), .serial_out_pin_i(sdo), .serial_out_oe_i(oe),
    .enable_o(en), .sck_o(sck), .sdi_o(sdi)
  );

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    liu_host_inst.xfer(a, d, 16, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    liu_host_inst.xfer(a, 8'h00, 16, rd);
    check(rd, e);
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (6) @(negedge clock_i);
    foreach (rows[i]) begin
      liu_host_inst.xfer(rows[i].a, rows[i].d, 16, rd);
      if (rows[i].a[0])
        check(rd, rows[i].e);
    end
    check({rate, par, refclk}, 4'hf);
    check(sig, 16'h5a00);
    // Hard reset reloads the strap
    strap = 2'b11;
    reset_i = 1'b1;
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check({rate, par, refclk}, 4'h3);
    check(irq, 2'b11);
    check(mode, 16'h0101);
    // Masked FIFO error, latched receive events
    wr(8'h02, 8'h02);
    ferr = 2'b01;
    rx_lol = 2'b01;
    rx_los = 2'b01;
    repeat (10) @(negedge clock_i);
    check(irq, 2'b11);
    ferr = 2'b00;
    rx_lol = 2'b00;
    rx_los = 2'b00;
    rdc(8'h1b, 8'h19);
    rdc(8'h1b, 8'h00);
    // Lock loss on channel one, both polarities
    tx_lol = 2'b10;
    repeat (10) @(negedge clock_i);
    check(irq, 2'b01);
    wr(8'h02, 8'ha3);
    check(irq, 2'b10);
    tx_lol = 2'b00;
    repeat (10) @(negedge clock_i);
    check(irq, 2'b10);
    rdc(8'h2b, 8'h02);
    repeat (10) @(negedge clock_i);
    check(irq, 2'b00);
    // FIFO error passed, then lock loss masked, active-high pin
    ferr = 2'b01;
    repeat (10) @(negedge clock_i);
    check(irq, 2'b01);
    ferr = 2'b00;
    rdc(8'h1b, 8'h01);
    wr(8'h02, 8'h81);
    tx_lol = 2'b01;
    repeat (10) @(negedge clock_i);
    check(irq, 2'b00);
    tx_lol = 2'b00;
    rdc(8'h1b, 8'h02);
    wr(8'h14, 8'h03);
    check(adv1, 16'h0003);
    // Soft reset restores defaults and clears itself
    strap = 2'b00;
    wr(8'h00, 8'h01);
    rdc(8'h01, 8'h00);
    rdc(8'h03, 8'h23);
    check(irq, 2'b11);
    check(mode2, 16'h8080);
    check(adv1, 16'h0000);
    check(adv0, 16'ha8a8);
    // Aborted write leaves the register alone
    liu_host_inst.xfer(8'h28, 8'h00, 12, rd);
    rdc(8'h29, 8'h80);
    wrap_up;
  end

  // Watchdog
  initial begin
    #1000000;
    fail_count++;
    $display("[ERR] t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule // liu_register_map_and_irq_tb_top
